// [dpio_pkg.sv]
// dpio_pkg: constants for the two-pin configuration register and pulse decoder
// assumes a single master clock and a 16-bit register port with 8-bit addresses
package dpio_pkg;
    localparam int          DPIO_CLK_PERIOD_NS = 50;
    localparam logic [7:0]  DPIO_CFG_ADDR      = 8'h81;
    localparam logic [15:0] DPIO_CFG_RESET     = 16'h8000;
    // field positions inside pin_pair_config
    localparam int DPIO_RSVD_BIT    = 15;
    localparam int DPIO_SPARE_HI_MS = 14;
    localparam int DPIO_SPARE_HI_LS = 12;
    localparam int DPIO_FMT1_BIT    = 11;
    localparam int DPIO_FMT0_BIT    = 10;
    localparam int DPIO_DIR1_BIT    = 9;
    localparam int DPIO_DIR0_BIT    = 8;
    localparam int DPIO_TB1_LS      = 6;
    localparam int DPIO_TB0_LS      = 4;
    localparam int DPIO_SPARE_LO_MS = 3;
    localparam int DPIO_SPARE_LO_LS = 2;
    localparam int DPIO_DAT1_BIT    = 1;
    localparam int DPIO_DAT0_BIT    = 0;
    // time base in master-clock periods per code
    localparam logic [10:0] DPIO_TB_CODE0 = 11'h010;
    localparam logic [10:0] DPIO_TB_CODE1 = 11'h040;
    localparam logic [10:0] DPIO_TB_CODE2 = 11'h100;
    localparam logic [10:0] DPIO_TB_CODE3 = 11'h400;
    localparam int          DPIO_CNT_W    = 8;
endpackage : dpio_pkg

// [dpio_pwm_if.sv]
// dpio_pwm_if: carries one pin's sampled level and time-base setup to its decoder
// assumes both ends sit on the same master clock
`timescale 1ns/10ps
`default_nettype none
interface dpio_pwm_if;
    logic       level;   // synchronised pin level
    logic [1:0] tb_sel;  // time base code
    logic       enable;  // decoding active
    logic       decoded; // decoded logic level
    modport dec  (input level, tb_sel, enable, output decoded);
    modport host (output level, tb_sel, enable, input decoded);
endinterface : dpio_pwm_if
`default_nettype wire

// [dpio_pwm_dec.sv]
// dpio_pwm_dec: measures high and low time of a pulse-width input in time-base units
// assumes its level input is already synchronised to clk_i
`timescale 1ns/10ps
`default_nettype none
module dpio_pwm_dec
    import dpio_pkg::*;
#(
    parameter int CNT_W = DPIO_CNT_W
)(
    input  wire logic  clk_i,   // master clock
    input  wire logic  reset_i, // async reset, high
    dpio_pwm_if.dec    pif      // pin link
);
    logic [10:0]      div_q;
    logic [10:0]      tb_len;
    logic             tick;
    logic             prev_q;
    logic [CNT_W-1:0] hi_q;
    logic [CNT_W-1:0] lo_q;
    logic             dec_q;
    logic             rise;
    logic             hi_full;
    logic             lo_full;

    // time base selection and tick decode
    assign tb_len  = (pif.tb_sel == 2'h0) ? DPIO_TB_CODE0 :
                     (pif.tb_sel == 2'h1) ? DPIO_TB_CODE1 :
                     (pif.tb_sel == 2'h2) ? DPIO_TB_CODE2 : DPIO_TB_CODE3; // RULE7
    // a shorter base chosen mid-count wraps at once instead of running to the top
    assign tick    = pif.enable && (div_q >= tb_len - 11'h001);
    assign rise    = pif.level && !prev_q;
    assign hi_full = &hi_q;
    assign lo_full = &lo_q;
    assign pif.decoded = dec_q;

    // divider restarts whenever decoding is off so timing is fresh on enable
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            div_q <= 11'h000;
        else if (!pif.enable || tick)
            div_q <= 11'h000;
        else
            div_q <= div_q + 11'h001;
    end

    // high and low counts in time-base units, period closes on a rising edge
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            prev_q <= 1'b0;
            hi_q   <= '0;
            lo_q   <= '0;
            dec_q  <= 1'b0;
        end
        else
        begin
            prev_q <= pif.level;
            if (!pif.enable)
            begin
                hi_q <= '0;
                lo_q <= '0;
            end
            else if (rise)
            begin
                // longer high than low means logic high
                dec_q <= (hi_q > lo_q); // RULE11 RULE10
                hi_q  <= '0;
                lo_q  <= '0;
            end
            else if (tick)
            begin
                if (pif.level && !hi_full)
                    hi_q <= hi_q + CNT_W'(1); // RULE11
                else if (!pif.level && !lo_full)
                    lo_q <= lo_q + CNT_W'(1); // RULE11
                // a saturated level with no edge counts as static
                if (pif.level && hi_full)
                    dec_q <= 1'b1;
                else if (!pif.level && lo_full)
                    dec_q <= 1'b0;
            end
        end
    end

    AST_TB_TICK: assert property (@(posedge clk_i) disable iff (reset_i) // RULE7
        (pif.enable && $past(pif.enable) && $stable(pif.tb_sel)) |-> div_q < tb_len)
        else $error("time base divider ran past its period");
    AST_COUNT_ON_TICK: assert property (@(posedge clk_i) disable iff (reset_i) // RULE11
        (pif.enable && !rise && !tick && $past(pif.enable)) |=> $stable(hi_q) && $stable(lo_q))
        else $error("duration counted without a time base tick");
    AST_CLASSIFY: assert property (@(posedge clk_i) disable iff (reset_i) // RULE10
        (pif.enable && rise) |=> dec_q == ($past(hi_q) > $past(lo_q)))
        else $error("period classified against wrong counts");
endmodule : dpio_pwm_dec
`default_nettype wire

// [dpio_top.sv]
// dpio_top: pin_pair_config register and logic for two general pins
// assumes a 16-bit register port on clk_i and raw asynchronous pin inputs
// pins: enable high while the block drives, drive value low when not driving
// Function
// RULE1: register at 81h resets to 8000h; bit 15 always reads one
// RULE2: spare bits 14:12 and 3:2 are plain storage with no effect
// RULE3: direction bit zero makes pin input, one makes it output
// RULE4: input with format zero takes its level from the static pin
// RULE5: input with format one takes its level from pulse-width decoding
// RULE6: outputs drive static levels only, never a pulse waveform
// RULE7: two-bit code selects 16, 64, 256 or 1024 clock time base
// RULE8: output pin follows its data bit, low for zero, high for one
// RULE9: data bit of an input pin is stored but does not drive
// RULE10: period is high plus low count times base; high time is high count
// RULE11: decoder counts high and low time in base units, classifies each period
`timescale 1ns/10ps
`default_nettype none
module dpio_top
    import dpio_pkg::*;
(
    input  wire logic        clk_i,       // master clock, 20 MHz
    input  wire logic        reset_i,     // async reset, high
    input  wire logic [7:0]  reg_addr_i,  // register address
    input  wire logic        reg_wr_i,    // write strobe
    input  wire logic [15:0] reg_wdata_i, // write data
    input  wire logic        reg_rd_i,    // read strobe
    output logic      [15:0] reg_rdata_o, // read data, one cycle after strobe
    input  wire logic [1:0]  pin_in_i,    // pin levels, asynchronous
    output logic      [1:0]  pin_out_o,   // pin drive value
    output logic      [1:0]  pin_oe_o,    // pin drive enable
    output logic      [1:0]  pin_level_o  // logic level seen per pin
);
    logic [14:0] cfg_q;
    logic [15:0] cfg_view;
    logic [1:0]  sync1_q;
    logic [1:0]  sync2_q;
    logic [1:0]  dir;
    logic [1:0]  fmt;
    logic [1:0]  dat;
    logic [1:0]  dec;
    logic [1:0]  level_d;
    logic        hit;
    logic [15:0] rdata_d;
    logic [1:0]  pin_oe_d;
    logic [1:0]  pin_out_d;

    // decode of the register and its fields
    assign hit      = (reg_addr_i == DPIO_CFG_ADDR);
    assign cfg_view = {1'b1, cfg_q}; // RULE1
    assign rdata_d  = (reg_rd_i && hit) ? cfg_view : 16'h0000;
    assign dir      = {cfg_q[DPIO_DIR1_BIT], cfg_q[DPIO_DIR0_BIT]};
    assign fmt      = {cfg_q[DPIO_FMT1_BIT], cfg_q[DPIO_FMT0_BIT]};
    assign dat      = {cfg_q[DPIO_DAT1_BIT], cfg_q[DPIO_DAT0_BIT]};

    // next pin drive: only the direction and data bits reach the pins
    assign pin_oe_d  = dir;       // RULE3
    assign pin_out_d = dir & dat; // RULE6 RULE8 RULE9

    // store of bits 14:0; spares are kept as plain storage and drive nothing
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            cfg_q <= DPIO_CFG_RESET[14:0]; // RULE1
        else if (reg_wr_i && hit)
            cfg_q <= reg_wdata_i[14:0]; // RULE2
    end

    // read data from a flop; unmapped addresses read zero
    // the flop also keeps the read mux off the output timing path
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            reg_rdata_o <= 16'h0000;
        else
            reg_rdata_o <= rdata_d;
    end

    // two-stage synchroniser for the asynchronous pins
    // only the second stage feeds logic; the decoder edge flop sits after it
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
        end
        else
        begin
            sync1_q <= pin_in_i;
            sync2_q <= sync1_q;
        end
    end

    // per-pin decoder and level selection
    // each pin has its own decoder, so the two time bases stay independent
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_pin
            dpio_pwm_if pif ();
            assign pif.level  = sync2_q[g];
            assign pif.tb_sel = (g == 1) ? cfg_q[DPIO_TB1_LS+1:DPIO_TB1_LS] // RULE7
                                         : cfg_q[DPIO_TB0_LS+1:DPIO_TB0_LS];
            assign pif.enable = !dir[g] && fmt[g];
            assign dec[g]     = pif.decoded;
            // static sampling or decoded level; an output reads back its own drive
            assign level_d[g] = dir[g] ? dat[g] :
                                fmt[g] ? dec[g] : sync2_q[g]; // RULE4 RULE5
            dpio_pwm_dec u_dec (
                .clk_i   (clk_i),
                .reset_i (reset_i),
                .pif     (pif)
            );
        end
    endgenerate

    // drive enable straight from a flop; high while the block drives the pin
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            pin_oe_o <= 2'h0;
        else
            pin_oe_o <= pin_oe_d; // RULE3
    end

    // drive value; the data bit gated by direction sets it, so no waveform can reach a pin
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            pin_out_o <= 2'h0;
        else
            pin_out_o <= pin_out_d; // RULE8 RULE6 RULE9
    end

    // reported level, one flop after the selection
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            pin_level_o <= 2'h0;
        else
            pin_level_o <= level_d;
    end

    // register port and per-pin checks
    AST_RESERVED_ONE: assert property (@(posedge clk_i) disable iff (reset_i) // RULE1
        (reg_rd_i && hit) |=> reg_rdata_o[15] && reg_rdata_o[14:0] == $past(cfg_q))
        else $error("register read back wrong or reserved bit not one");
    AST_SPARE_STORE: assert property (@(posedge clk_i) disable iff (reset_i) // RULE2
        (reg_wr_i && hit) |=> cfg_q[14:12] == $past(reg_wdata_i[14:12])
                              && cfg_q[3:2] == $past(reg_wdata_i[3:2]))
        else $error("spare bits not stored");
    AST_DIR_ENABLE: assert property (@(posedge clk_i) disable iff (reset_i) // RULE3
        ##1 pin_oe_o == $past(dir))
        else $error("drive enable does not follow direction");
    AST_STATIC_IN: assert property (@(posedge clk_i) disable iff (reset_i) // RULE4
        (!dir[0] && !fmt[0]) |=> pin_level_o[0] == $past(sync2_q[0]))
        else $error("static input level not taken from pin");
    AST_PULSE_IN: assert property (@(posedge clk_i) disable iff (reset_i) // RULE5
        (!dir[1] && fmt[1]) |=> pin_level_o[1] == $past(dec[1]))
        else $error("pulse input level not taken from decoder");
    AST_NO_WAVE: assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
        (dir[0] && $stable(dat[0]) && $past(dir[0])) |=> $stable(pin_out_o[0]))
        else $error("output toggled without a data change");
    AST_OUT_DATA: assert property (@(posedge clk_i) disable iff (reset_i) // RULE8
        dir[1] |=> pin_oe_o[1] && pin_out_o[1] == $past(dat[1]))
        else $error("output level does not match data bit");
    AST_IN_NO_DRIVE: assert property (@(posedge clk_i) disable iff (reset_i) // RULE9
        (!dir[0] && dat[0]) |=> !pin_oe_o[0] && !pin_out_o[0])
        else $error("input pin driven by its data bit");

    // register port: refused accesses leave no trace, spare-only writes leave the pin drive alone
    AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (reset_i) // RULE1
        !(reg_rd_i && hit) |=> reg_rdata_o == 16'h0000)
        else $error("read data shown without a read of the register");
    AST_WR_OTHER: assert property (@(posedge clk_i) disable iff (reset_i) // RULE1
        !(reg_wr_i && hit) |=> cfg_q == $past(cfg_q))
        else $error("register changed without a write to its address");
    AST_SPARE_NONE: assert property (@(posedge clk_i) disable iff (reset_i) // RULE2
        (reg_wr_i && hit && ((reg_wdata_i ^ cfg_view) & 16'h0FF3) == 16'h0000)
        |=> ##1 $stable(pin_oe_o) && $stable(pin_out_o))
        else $error("spare bits changed the pin drive");

    // the same pin checks for the other pin of the pair
    AST_STATIC_IN1: assert property (@(posedge clk_i) disable iff (reset_i) // RULE4
        (!dir[1] && !fmt[1]) |=> pin_level_o[1] == $past(sync2_q[1]))
        else $error("static input level not taken from pin");
    AST_PULSE_IN0: assert property (@(posedge clk_i) disable iff (reset_i) // RULE5
        (!dir[0] && fmt[0]) |=> pin_level_o[0] == $past(dec[0]))
        else $error("pulse input level not taken from decoder");
    AST_NO_WAVE1: assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
        (dir[1] && $stable(dat[1]) && $past(dir[1])) |=> $stable(pin_out_o[1]))
        else $error("output toggled without a data change");
    AST_OUT_DATA0: assert property (@(posedge clk_i) disable iff (reset_i) // RULE8
        dir[0] |=> pin_oe_o[0] && pin_out_o[0] == $past(dat[0]))
        else $error("output level does not match data bit");
    AST_IN_NO_DRIVE1: assert property (@(posedge clk_i) disable iff (reset_i) // RULE9
        (!dir[1] && dat[1]) |=> !pin_oe_o[1] && !pin_out_o[1])
        else $error("input pin driven by its data bit");

    // an output reports its own data bit; a pin not driven keeps its drive value low
    AST_OUT_LEVEL0: assert property (@(posedge clk_i) disable iff (reset_i) // RULE8
        dir[0] |=> pin_level_o[0] == $past(dat[0]))
        else $error("output pin level does not follow its data bit");
    AST_OUT_LEVEL1: assert property (@(posedge clk_i) disable iff (reset_i) // RULE8
        dir[1] |=> pin_level_o[1] == $past(dat[1]))
        else $error("output pin level does not follow its data bit");
    AST_OE_OUT0: assert property (@(posedge clk_i) disable iff (reset_i) // RULE9
        !pin_oe_o[0] |-> !pin_out_o[0])
        else $error("drive value high while the pin is not driven");
    AST_OE_OUT1: assert property (@(posedge clk_i) disable iff (reset_i) // RULE9
        !pin_oe_o[1] |-> !pin_out_o[1])
        else $error("drive value high while the pin is not driven");

    // a decoder that is not selected holds its counts cleared
    AST_DEC_OFF0: assert property (@(posedge clk_i) disable iff (reset_i) // RULE5
        (dir[0] || !fmt[0]) |=> g_pin[0].u_dec.hi_q == '0 && g_pin[0].u_dec.lo_q == '0)
        else $error("pulse decoder counting while not selected");
    AST_DEC_OFF1: assert property (@(posedge clk_i) disable iff (reset_i) // RULE5
        (dir[1] || !fmt[1]) |=> g_pin[1].u_dec.hi_q == '0 && g_pin[1].u_dec.lo_q == '0)
        else $error("pulse decoder counting while not selected");
endmodule : dpio_top
`default_nettype wire

// [dpio_pin_model.sv]
// dpio_pin_model: outside source for one general pin, static level or pulse waveform
// assumes the master clock; its source changes the pin on falling edges only
`timescale 1ns/10ps
`default_nettype none
module dpio_pin_model (
    input  wire logic        clk_i, // master clock
    input  wire logic        pwm_i, // send a waveform
    input  wire logic        lvl_i, // static level
    input  wire logic [15:0] hi_i,  // high time in clocks
    input  wire logic [15:0] lo_i,  // low time in clocks
    input  wire logic        oe_i,  // device drives the pin
    input  wire logic        out_i, // device drive value
    output logic             pin_o  // resolved pin level
);
    logic [15:0] cnt_q = 16'h0000;
    logic        ph_q  = 1'b1;

    // high phase first; period is the sum of both phases
    always @(negedge clk_i)
    begin
        cnt_q <= cnt_q + 16'h0001;
        if (!pwm_i || (cnt_q + 16'h0001) >= (ph_q ? hi_i : lo_i))
        begin
            cnt_q <= 16'h0000;
            ph_q  <= pwm_i ? !ph_q : 1'b1;
        end
    end

    // the device's drive wins, so the outside source is hidden while the device drives
    assign pin_o = oe_i ? out_i : (pwm_i ? ph_q : lvl_i);
endmodule : dpio_pin_model
`default_nettype wire

// [tb_top.sv]
// tb_top: register and pin tests for the two-pin block
// assumes one 20 MHz clock; pins come from two outside source models
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk_i       = 1'b0;
    logic        reset_i     = 1'b1;
    logic [7:0]  reg_addr_i  = 8'h00;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [15:0] reg_rdata_o;
    logic [1:0]  pin_out_o, pin_oe_o, pin_level_o;
    wire  [1:0]  pin_in_i;
    logic [1:0]  pwm_q = 2'b00;
    logic [1:0]  lvl_q = 2'b00;
    logic [15:0] hi_q[2] = '{16'h0001, 16'h0001};
    logic [15:0] lo_q[2] = '{16'h0001, 16'h0001};
    int          fails = 0;
    int          checked = 0;
    int          cyc = 0;

    always #25 clk_i = ~clk_i;

    dpio_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o), .pin_level_o(pin_level_o));

    // one outside source per pin
    for (genvar g = 0; g < 2; g++)
    begin : g_pin
        dpio_pin_model i_pin (.clk_i(clk_i), .pwm_i(pwm_q[g]), .lvl_i(lvl_q[g]),
            .hi_i(hi_q[g]), .lo_i(lo_q[g]), .oe_i(pin_oe_o[g]),
            .out_i(pin_out_o[g]), .pin_o(pin_in_i[g]));
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_i);
        reg_addr_i  = a;
        reg_wdata_i = d;
        reg_wr_i    = 1'b1;
        @(negedge clk_i);
        reg_wr_i    = 1'b0;
    endtask : wr

    // read data stands for the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i   = 1'b1;
        @(negedge clk_i);
        reg_rd_i   = 1'b0;
        chk("reg_rdata_o", reg_rdata_o, e);
    endtask : rd

    // pins show a write two edges after the strobe; a pin level three more
    task automatic pins(input logic [1:0] oe, input logic [1:0] out, input logic [1:0] lvl);
        repeat (5) @(negedge clk_i);
        chk("pin_oe_o", {14'h0000, pin_oe_o}, {14'h0000, oe});
        chk("pin_out_o", {14'h0000, pin_out_o}, {14'h0000, out});
        chk("pin_level_o", {14'h0000, pin_level_o}, {14'h0000, lvl});
    endtask : pins

    task automatic report_and_stop;
        $display("counts: %0d checked, %0d failed", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    // hang guard, above the longest pulse test
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            fails++;
            report_and_stop();
        end
    end

    initial
    begin
        int tb;
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        rd(8'h81, 16'h8000);
        wr(8'h82, 16'h7FFF);
        rd(8'h80, 16'h0000);
        rd(8'h81, 16'h8000);
        wr(8'h81, 16'h7FFF);
        rd(8'h81, 16'hFFFF);
        pins(2'b11, 2'b11, 2'b11);
        wr(8'h81, 16'h7302);
        pins(2'b11, 2'b10, 2'b10);
        wr(8'h81, 16'h0302);
        pins(2'b11, 2'b10, 2'b10);
        rd(8'h81, 16'h8302);
        wr(8'h81, 16'h0001);
        pins(2'b00, 2'b00, 2'b00);
        $display("test registers and outputs done");
        lvl_q = 2'b10;
        wr(8'h81, 16'h0003);
        pins(2'b00, 2'b00, 2'b10);
        $display("test static inputs done");
        // pin 0 mostly high, pin 1 mostly low, every time base
        pwm_q = 2'b11;
        for (int k = 0; k < 4; k++)
        begin
            tb = 16 << (2 * k);
            hi_q[0] = 16'(10 * tb);
            lo_q[0] = 16'(5 * tb);
            hi_q[1] = 16'(3 * tb);
            lo_q[1] = 16'(9 * tb);
            wr(8'h81, 16'h0C00 | 16'(k << 6) | 16'(k << 4));
            repeat (45 * tb) @(negedge clk_i);
            chk("pin_level_o", {14'h0000, pin_level_o}, 16'h0001);
        end
        $display("test pulse inputs done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
